/* design/tpw_defs.svh */
// register offsets, field positions, reset values and counter constants of the pwm timer
`ifndef TPW_DEFS_SVH
`define TPW_DEFS_SVH
`define TPW_OFF_CTRL0 8'h00
`define TPW_OFF_MODE 8'h04
`define TPW_OFF_PINCTL 8'h08
`define TPW_OFF_CAPCTL 8'h0C
`define TPW_OFF_EDGECTL 8'h10
`define TPW_OFF_OPT 8'h14
`define TPW_OFF_CNT 8'h18
`define TPW_OFF_CCR0 8'h1C
`define TPW_OFF_CCR1 8'h20
`define TPW_OFF_CCR2 8'h24
`define TPW_OFF_CCR3 8'h28
`define TPW_CE_BIT 7
`define TPW_CTRL0_MASK 8'h87
`define TPW_MODE_PWM 3'h4
`define TPW_EN0_BIT 0
`define TPW_LVL0_BIT 1
`define TPW_RST_BYTE 8'h00
`define TPW_RST_MODE 3'h0
`define TPW_RST_WORD 16'h0000
`define TPW_CNT_IDLE 16'hFFFF
`define TPW_CNT_ZERO 16'h0000
`define TPW_CNT_STEP 16'h0001
`endif

/* design/tpw_pkg.sv */
// types shared by the pwm timer modules
package tpw_pkg;
  typedef enum logic [2:0] {
    TPW_ST_IDLE = 3'b001,
    TPW_ST_WAIT = 3'b010,
    TPW_ST_RUN = 3'b100
  } tpw_state_t;

  typedef struct packed {
    tpw_state_t state;
    logic [7:0] ctrl0;
    logic [2:0] mode;
    logic [7:0] pin_ctl;
    logic [7:0] cap_ctl;
    logic [7:0] edge_ctl;
    logic [7:0] opt;
    logic [3:0][15:0] ccr;
    logic [3:0][15:0] bufs;
    logic [15:0] cnt;
    logic armed;
    logic sq;
    logic moved;
    logic wrap;
    logic [3:0] pins;
    logic period_irq;
    logic [2:0] duty_irq;
    logic [31:0] rdata;
  } tpw_core_t;

  typedef struct packed {
    logic [7:0] div;
  } tpw_pre_t;
endpackage

/* design/tpw_prescale.sv */
// count clock generator: one tick every 2**sel system clocks
`timescale 1ns/1ps
`default_nettype none
module tpw_prescale
  import tpw_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic restart_i,
  input wire logic [2:0] sel_i,
  output logic tick_o
);
  tpw_pre_t p_q;
  tpw_pre_t p_d;
  logic [7:0] mask;

  assign mask = 8'((9'h001 << sel_i) - 9'h001);
  // gated by ce so a frozen block never sees a tick
  assign tick_o = ce_i && ((p_q.div & mask) == mask);

  always_comb begin
    p_d = p_q;
    if (restart_i) begin
      // restart keeps the first period whole for a new selection
      p_d.div = 8'h00;
    end else begin
      p_d.div = 8'(p_q.div + 8'h01);
    end
    if (!ce_i) begin
      p_d = p_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      p_q <= '0;
    end else begin
      p_q <= p_d;
    end
  end
endmodule
`default_nettype wire

/* design/tpw_chan.sv */
// one duty channel: active window and match compare against its buffered value
`timescale 1ns/1ps
`default_nettype none
module tpw_chan #(
  parameter int W = 16
) (
  input wire logic [W-1:0] cnt_i,
  input wire logic [W-1:0] cmp_i,
  output logic active_o,
  output logic match_o
);
  // zero never active, period plus one always active
  assign active_o = (cnt_i < cmp_i); // R6 R13 R14 R22
  assign match_o = (cnt_i == cmp_i); // R10
endmodule
`default_nettype wire

/* design/tpw_pwm_top.sv */
// pwm output mode of a 16-bit timer with four compare channels and register port
//
// Behaviour
// (R1) mode field 100 selects pwm operation
// (R2) count enable starts pwm on channels 1-3
// (R3) channel 0 pin toggles once per period
// (R4) enable moves counter FFFFH to 0000H, counts up
// (R5) period is buffered period value plus one
// (R6) active width equals buffered duty value
// (R7) compare writes apply only at counter clear
// (R8) channel 1 write arms the buffer transfer
// (R9) period irq coincides with counter clearing
// (R10) duty irq when counter equals duty value
// (R11) software writes channel 1 compare last
// (R12) software waits period irq before rewriting
// (R13) duty zero gives always inactive output
// (R14) duty period plus one gives always active
// (R15) each pin has own output enable bit
// (R16) level select bit inverts channels 1-3
// (R17) channel 0 level bit drives disabled pin
// (R18) software clears unused channel 0 bits
// (R19) counter readable through read-only register
// (R20) capture and option registers do nothing
// (R21) clock select may change with enable
// (R22) active from clear until compare passed
// (R23) disabling stops, idles counter, outputs inactive
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tpw_defs.svh"
module tpw_pwm_top
  import tpw_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic square_wave_pin_o,
  output logic [2:0] pwm_output_pin_o,
  output logic period_match_irq_o,
  output logic [2:0] duty_match_irq_o
);
  tpw_core_t s_q;
  tpw_core_t s_d;
  logic tick;
  logic run_req;
  logic [2:0] act;
  logic [2:0] mat;

  function automatic logic [31:0] tpw_zext8(input logic [7:0] v);
    tpw_zext8 = {24'h000000, v};
  endfunction

  function automatic logic [31:0] tpw_zext16(input logic [15:0] v);
    tpw_zext16 = {16'h0000, v};
  endfunction

  // any mode other than pwm keeps this block idle
  assign run_req = s_q.ctrl0[`TPW_CE_BIT] && (s_q.mode == `TPW_MODE_PWM); // R1 R2

  tpw_prescale u_prescale (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .restart_i(s_q.state == TPW_ST_IDLE), // R21
    .sel_i(s_q.ctrl0[2:0]),
    .tick_o(tick)
  );

  genvar g;
  for (g = 0; g < 3; g++) begin : g_chan
    tpw_chan #(.W(16)) u_chan (
      .cnt_i(s_q.cnt),
      .cmp_i(s_q.bufs[g+1]),
      .active_o(act[g]),
      .match_o(mat[g])
    );
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h00000000;
    s_d.moved = 1'b0;
    s_d.wrap = 1'b0;

    if (rd_i) begin
      case (addr_i)
        `TPW_OFF_CTRL0: s_d.rdata = tpw_zext8(s_q.ctrl0);
        `TPW_OFF_MODE: s_d.rdata = tpw_zext8({5'h00, s_q.mode});
        `TPW_OFF_PINCTL: s_d.rdata = tpw_zext8(s_q.pin_ctl);
        `TPW_OFF_CAPCTL: s_d.rdata = tpw_zext8(s_q.cap_ctl);
        `TPW_OFF_EDGECTL: s_d.rdata = tpw_zext8(s_q.edge_ctl);
        `TPW_OFF_OPT: s_d.rdata = tpw_zext8(s_q.opt);
        `TPW_OFF_CNT: s_d.rdata = tpw_zext16(s_q.cnt); // R19
        `TPW_OFF_CCR0: s_d.rdata = tpw_zext16(s_q.ccr[0]);
        `TPW_OFF_CCR1: s_d.rdata = tpw_zext16(s_q.ccr[1]);
        `TPW_OFF_CCR2: s_d.rdata = tpw_zext16(s_q.ccr[2]);
        `TPW_OFF_CCR3: s_d.rdata = tpw_zext16(s_q.ccr[3]);
        default: s_d.rdata = 32'h00000000;
      endcase
    end

    unique case (s_q.state)
      TPW_ST_IDLE: begin
        // stopped: buffers follow the registers so a start uses fresh values
        s_d.cnt = `TPW_CNT_IDLE; // R23
        s_d.bufs = s_q.ccr;
        s_d.sq = 1'b0;
        s_d.armed = 1'b0;
        if (run_req) begin
          s_d.state = TPW_ST_WAIT; // R2
        end
      end
      TPW_ST_WAIT: begin
        if (!run_req) begin
          s_d.state = TPW_ST_IDLE; // R23
        end else if (tick) begin
          s_d.cnt = `TPW_CNT_ZERO; // R4
          s_d.bufs = s_q.ccr;
          s_d.armed = 1'b0;
          s_d.moved = 1'b1;
          s_d.state = TPW_ST_RUN;
        end
      end
      TPW_ST_RUN: begin
        if (!run_req) begin
          s_d.state = TPW_ST_IDLE; // R23
          s_d.cnt = `TPW_CNT_IDLE;
        end else if (tick) begin
          s_d.moved = 1'b1;
          if (s_q.cnt == s_q.bufs[0]) begin
            s_d.cnt = `TPW_CNT_ZERO; // R5
            s_d.wrap = 1'b1;
            s_d.sq = !s_q.sq; // R3
            if (s_q.armed) begin
              s_d.bufs = s_q.ccr; // R7 R8
              s_d.armed = 1'b0;
            end
          end else begin
            s_d.cnt = s_q.cnt + `TPW_CNT_STEP; // R4
          end
        end
      end
    endcase

    // writes last, so an arming write beside a transfer is kept
    if (wr_i) begin
      case (addr_i)
        `TPW_OFF_CTRL0: s_d.ctrl0 = wdata_i[7:0] & `TPW_CTRL0_MASK; // R21
        `TPW_OFF_MODE: s_d.mode = wdata_i[2:0]; // R1
        `TPW_OFF_PINCTL: s_d.pin_ctl = wdata_i[7:0];
        // stored and read back only, they steer nothing here
        `TPW_OFF_CAPCTL: s_d.cap_ctl = wdata_i[7:0]; // R20
        `TPW_OFF_EDGECTL: s_d.edge_ctl = wdata_i[7:0];
        `TPW_OFF_OPT: s_d.opt = wdata_i[7:0]; // R20
        `TPW_OFF_CCR0: s_d.ccr[0] = wdata_i[15:0];
        `TPW_OFF_CCR1: begin
          s_d.ccr[1] = wdata_i[15:0];
          if (s_q.state != TPW_ST_IDLE) begin
            s_d.armed = 1'b1; // R8
          end
        end
        `TPW_OFF_CCR2: s_d.ccr[2] = wdata_i[15:0];
        `TPW_OFF_CCR3: s_d.ccr[3] = wdata_i[15:0];
        default: s_d.armed = s_d.armed;
      endcase
    end

    // outputs follow the counter by one system clock, all alike
    s_d.period_irq = s_q.wrap; // R9
    for (int k = 0; k < 3; k++) begin
      s_d.duty_irq[k] = s_q.moved && (s_q.state == TPW_ST_RUN) && mat[k]; // R10 R13
      if (s_q.pin_ctl[2*k+2]) begin
        s_d.pins[k+1] = ((s_q.state == TPW_ST_RUN) && act[k]) ^ s_q.pin_ctl[2*k+3]; // R16 R22
      end else begin
        s_d.pins[k+1] = 1'b0; // R15
      end
    end
    if (s_q.pin_ctl[`TPW_EN0_BIT]) begin
      s_d.pins[0] = s_q.sq; // R3 R15
    end else begin
      s_d.pins[0] = s_q.pin_ctl[`TPW_LVL0_BIT]; // R17
    end

    if (!ce_i) begin
      s_d = s_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s_q.state <= TPW_ST_IDLE;
      s_q.ctrl0 <= `TPW_RST_BYTE;
      s_q.mode <= `TPW_RST_MODE;
      s_q.pin_ctl <= `TPW_RST_BYTE;
      s_q.cap_ctl <= `TPW_RST_BYTE;
      s_q.edge_ctl <= `TPW_RST_BYTE;
      s_q.opt <= `TPW_RST_BYTE;
      s_q.ccr <= {4{`TPW_RST_WORD}};
      s_q.bufs <= {4{`TPW_RST_WORD}};
      s_q.cnt <= `TPW_CNT_IDLE;
      s_q.armed <= 1'b0;
      s_q.sq <= 1'b0;
      s_q.moved <= 1'b0;
      s_q.wrap <= 1'b0;
      s_q.pins <= 4'h0;
      s_q.period_irq <= 1'b0;
      s_q.duty_irq <= 3'h0;
      s_q.rdata <= 32'h00000000;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign square_wave_pin_o = s_q.pins[0];
  assign pwm_output_pin_o = s_q.pins[3:1];
  assign period_match_irq_o = s_q.period_irq;
  assign duty_match_irq_o = s_q.duty_irq;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_wrap;
    (s_q.state == TPW_ST_RUN) && run_req && tick && (s_q.cnt == s_q.bufs[0]);
  endsequence

  sequence s_start;
    (s_q.state == TPW_ST_WAIT) && run_req && tick;
  endsequence

  property p_mode_leave;
    ((s_q.state != TPW_ST_IDLE) && (s_q.mode != `TPW_MODE_PWM) && ce_i)
      |=> (s_q.state == TPW_ST_IDLE);
  endproperty
  a_mode_leave: assert property (p_mode_leave) else $error("left pwm mode but kept running"); // R1

  property p_start;
    s_start |=> (s_q.cnt == `TPW_CNT_ZERO) && (s_q.state == TPW_ST_RUN);
  endproperty
  a_start: assert property (p_start) else $error("start did not clear counter"); // R4

  property p_count;
    ((s_q.state == TPW_ST_RUN) && run_req && tick && (s_q.cnt != s_q.bufs[0]))
      |=> (s_q.cnt == $past(s_q.cnt) + `TPW_CNT_STEP);
  endproperty
  a_count: assert property (p_count) else $error("counter did not step by one"); // R4

  property p_wrap;
    s_wrap |=> (s_q.cnt == `TPW_CNT_ZERO) ##1 (!$past(ce_i) || period_match_irq_o);
  endproperty
  a_wrap: assert property (p_wrap) else $error("period match did not clear and signal"); // R5 R9

  property p_irq_cause;
    period_match_irq_o |-> ($past(s_q.cnt, 1) == `TPW_CNT_ZERO) && $past(s_q.wrap);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("period irq without clear"); // R9

  property p_duty_irq;
    duty_match_irq_o[0] |-> ($past(s_q.cnt) == $past(s_q.bufs[1]));
  endproperty
  a_duty_irq: assert property (p_duty_irq) else $error("duty irq without match"); // R10

  property p_hold_buf;
    ((s_q.state == TPW_ST_RUN) && (s_q.cnt != s_q.bufs[0])) |=> $stable(s_q.bufs);
  endproperty
  a_hold_buf: assert property (p_hold_buf) else $error("buffer changed mid period"); // R7

  property p_arm;
    $rose(s_q.armed) |-> $past(wr_i && (addr_i == `TPW_OFF_CCR1));
  endproperty
  a_arm: assert property (p_arm) else $error("transfer armed without channel 1 write"); // R8

  property p_zero_duty;
    ((s_q.state == TPW_ST_RUN) && (s_q.bufs[1] == `TPW_CNT_ZERO) && ce_i)
      |=> (pwm_output_pin_o[0] == ($past(s_q.pin_ctl[2]) && $past(s_q.pin_ctl[3])));
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("zero duty output not inactive"); // R13

  property p_square;
    (period_match_irq_o && $past(s_q.pin_ctl[0]) && $past(s_q.pin_ctl[0], 2))
      |-> (square_wave_pin_o != $past(square_wave_pin_o));
  endproperty
  a_square: assert property (p_square) else $error("square wave did not toggle"); // R3

  property p_cnt_read;
    (rd_i && (addr_i == `TPW_OFF_CNT) && ce_i) |=> (rdata_o == {16'h0000, $past(s_q.cnt)});
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("counter read mismatch"); // R19

  property p_stop;
    ((s_q.state != TPW_ST_IDLE) && !run_req && ce_i)
      |=> (s_q.state == TPW_ST_IDLE) && (s_q.cnt == `TPW_CNT_IDLE);
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not idle counter"); // R23

  property p_enter_wait;
    ((s_q.state == TPW_ST_IDLE) && run_req && ce_i) |=> (s_q.state == TPW_ST_WAIT);
  endproperty
  a_enter_wait: assert property (p_enter_wait) else $error("enable did not leave idle"); // R2

  property p_clear_active;
    s_wrap ##1 (s_q.pin_ctl[2] && !s_q.pin_ctl[3] && (s_q.bufs[1] != `TPW_CNT_ZERO) && ce_i)
      |=> pwm_output_pin_o[0];
  endproperty
  a_clear_active: assert property (p_clear_active) else $error("ch1 idle after clear"); // R22

  property p_full_on;
    ((s_q.state == TPW_ST_RUN) && (s_q.bufs[3] > s_q.bufs[0]) && s_q.pin_ctl[6]
      && !s_q.pin_ctl[7] && ce_i) |=> pwm_output_pin_o[2];
  endproperty
  a_full_on: assert property (p_full_on) else $error("full duty output not active"); // R14

  property p_dis_pin;
    (!s_q.pin_ctl[4] && ce_i) |=> !pwm_output_pin_o[1];
  endproperty
  a_dis_pin: assert property (p_dis_pin) else $error("disabled pin not low"); // R15

  property p_level0;
    (!s_q.pin_ctl[`TPW_EN0_BIT] && ce_i)
      |=> (square_wave_pin_o == $past(s_q.pin_ctl[`TPW_LVL0_BIT]));
  endproperty
  a_level0: assert property (p_level0) else $error("disabled square pin level wrong"); // R17

  property p_low_idle;
    ((s_q.state == TPW_ST_IDLE) && s_q.pin_ctl[4] && s_q.pin_ctl[5] && ce_i)
      |=> pwm_output_pin_o[1];
  endproperty
  a_low_idle: assert property (p_low_idle) else $error("active-low pin not high when idle"); // R16 R23

  property p_duty_irq_two;
    duty_match_irq_o[1] |-> ($past(s_q.cnt) == $past(s_q.bufs[2]));
  endproperty
  a_duty_irq_two: assert property (p_duty_irq_two) else $error("ch2 duty irq without match"); // R10

  property p_rdata_idle;
    (!rd_i && ce_i) |=> (rdata_o == 32'h00000000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle"); // R19
endmodule
`default_nettype wire

/* tb/tpw_load_model.sv */
// load model: high time and duty irq count of each pwm pin per period
`timescale 1ns/1ps
`default_nettype none
module tpw_load_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [2:0] pin_i,
  input wire logic period_irq_i,
  input wire logic [2:0] duty_irq_i,
  output logic [2:0][15:0] high_o,
  output logic [2:0][3:0] irqs_o,
  output logic [15:0] len_o
);
  logic [2:0][15:0] high_q;
  logic [2:0][3:0] irq_q;
  logic [15:0] len_q;
  // a window opens at each period irq; pins lag the counter just as the irq does
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      high_q <= '0;
      irq_q <= '0;
      len_q <= 16'h0000;
      high_o <= '0;
      irqs_o <= '0;
      len_o <= 16'h0000;
    end else if (period_irq_i) begin
      high_o <= high_q;
      irqs_o <= irq_q;
      len_o <= len_q;
      len_q <= 16'h0001;
      for (int k = 0; k < 3; k++) begin
        high_q[k] <= {15'h0000, pin_i[k]};
        irq_q[k] <= {3'h0, duty_irq_i[k]};
      end
    end else begin
      len_q <= len_q + 16'h0001;
      for (int k = 0; k < 3; k++) begin
        high_q[k] <= high_q[k] + {15'h0000, pin_i[k]};
        irq_q[k] <= irq_q[k] + {3'h0, duty_irq_i[k]};
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb_tpw_pwm_top.sv */
// testbench of the pwm timer: register port tasks and pin measurements
`timescale 1ns/1ps
`default_nettype none
`include "tpw_defs.svh"
module tb_tpw_pwm_top;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic square_wave_pin_o;
  logic [2:0] pwm_output_pin_o;
  logic period_match_irq_o;
  logic [2:0] duty_match_irq_o;
  logic [2:0][15:0] high;
  logic [2:0][3:0] irqs;
  logic [15:0] len;
  logic [31:0] d;
  logic s0;
  int n_fail = 0;
  int checked = 0;
  logic [7:0] offs [8] = '{`TPW_OFF_CTRL0, `TPW_OFF_MODE, `TPW_OFF_PINCTL, `TPW_OFF_CCR0,
    `TPW_OFF_CCR1, `TPW_OFF_CCR2, `TPW_OFF_CCR3, 8'h30};

  always #5 sys_clk_i = ~sys_clk_i;

  tpw_pwm_top u_tpw_pwm_top (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .square_wave_pin_o(square_wave_pin_o), .pwm_output_pin_o(pwm_output_pin_o),
    .period_match_irq_o(period_match_irq_o), .duty_match_irq_o(duty_match_irq_o));

  tpw_load_model u_tpw_load_model (.clk_i(sys_clk_i), .reset_i(reset_i),
    .pin_i(pwm_output_pin_o), .period_irq_i(period_match_irq_o),
    .duty_irq_i(duty_match_irq_o), .high_o(high), .irqs_o(irqs), .len_o(len));

  task automatic cmp(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask

  // bounded wait for n period irqs, then one edge so the model has latched
  task automatic wait_irq(input int n);
    int i;
    repeat (n) begin
      i = 0;
      do begin
        @(posedge sys_clk_i);
        #1;
        i++;
      end while (period_match_irq_o !== 1'b1 && i < 300);
      if (i >= 300) begin
        n_fail++;
        $display("MISMATCH period irq wait expected 1 seen 0");
      end
    end
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic meas(input logic [15:0] l, input logic [15:0] h0, input logic [15:0] h1,
      input logic [15:0] h2);
    cmp("period length", {16'h0, len}, {16'h0, l});
    cmp("high ch1", {16'h0, high[0]}, {16'h0, h0});
    cmp("high ch2", {16'h0, high[1]}, {16'h0, h1});
    cmp("high ch3", {16'h0, high[2]}, {16'h0, h2});
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #500000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    wr(`TPW_OFF_CNT, 32'h1234);
    // registers clear, unmapped reads zero, counter idles and ignores writes
    foreach (offs[i]) begin
      rd(offs[i], d);
      cmp("reset value", d, 32'h0);
    end
    rd(`TPW_OFF_CNT, d);
    cmp("idle counter", d, 32'hFFFF);
    // period 5, ch1 duty 2, ch2 duty 0 active-low, ch3 full on
    wr(`TPW_OFF_CCR0, 32'h4);
    wr(`TPW_OFF_CCR2, 32'h0);
    wr(`TPW_OFF_CCR3, 32'h5);
    wr(`TPW_OFF_CCR1, 32'h2);
    wr(`TPW_OFF_PINCTL, 32'h75);
    wr(`TPW_OFF_MODE, 32'h4);
    wr(`TPW_OFF_CTRL0, 32'h80);
    // counter holds its idle value until the first count tick
    rd(`TPW_OFF_CNT, d);
    cmp("waiting for tick", d, 32'hFFFF);
    rd(`TPW_OFF_CNT, d);
    cmp("counting", d, 32'h1);
    wait_irq(3);
    meas(16'h5, 16'h2, 16'h5, 16'h5);
    cmp("duty irqs", {20'h0, irqs}, {20'h0, 4'h0, 4'h1, 4'h1});
    s0 = square_wave_pin_o;
    wait_irq(1);
    cmp("square toggles", {31'h0, square_wave_pin_o}, {31'h0, ~s0});
    // unarmed write and dead registers change nothing
    wr(`TPW_OFF_CCR2, 32'h3);
    wr(`TPW_OFF_CAPCTL, 32'hFF);
    wr(`TPW_OFF_OPT, 32'hFF);
    wr(`TPW_OFF_EDGECTL, 32'hFF);
    wait_irq(2);
    meas(16'h5, 16'h2, 16'h5, 16'h5);
    // same value to ch1 arms the transfer, then wait two period irqs
    wr(`TPW_OFF_CCR1, 32'h2);
    wait_irq(2);
    meas(16'h5, 16'h2, 16'h2, 16'h5);
    wr(`TPW_OFF_CCR0, 32'h9);
    wr(`TPW_OFF_CCR1, 32'h3);
    wait_irq(2);
    meas(16'hA, 16'h3, 16'h7, 16'h5);
    rd(`TPW_OFF_CNT, d);
    cmp("running counter", {31'h0, d <= 32'h9}, 32'h1);
    // stop: counter idles, pins inactive
    wr(`TPW_OFF_CTRL0, 32'h0);
    rd(`TPW_OFF_CNT, d);
    cmp("stopped counter", d, 32'hFFFF);
    cmp("inactive pins", {29'h0, pwm_output_pin_o}, 32'h2);
    wr(`TPW_OFF_PINCTL, 32'h2);
    rd(`TPW_OFF_PINCTL, d);
    cmp("pin control", d, 32'h2);
    cmp("square level", {31'h0, square_wave_pin_o}, 32'h1);
    cmp("disabled pins", {29'h0, pwm_output_pin_o}, 32'h0);
    // other mode never counts
    wr(`TPW_OFF_PINCTL, 32'h4);
    wr(`TPW_OFF_MODE, 32'h5);
    wr(`TPW_OFF_CTRL0, 32'h80);
    repeat (10) @(posedge sys_clk_i);
    rd(`TPW_OFF_CNT, d);
    cmp("wrong mode", d, 32'hFFFF);
    // restart with clock select 1 in the enabling write: ticks every 2 clocks
    wr(`TPW_OFF_CTRL0, 32'h0);
    wr(`TPW_OFF_MODE, 32'h4);
    wr(`TPW_OFF_CTRL0, 32'h81);
    wait_irq(3);
    meas(16'h14, 16'h6, 16'h0, 16'h0);
    // freeze 40 clocks while ch1 is active: window stretches, high time grows by 40
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    repeat (40) @(posedge sys_clk_i);
    ce_i <= 1'b1;
    wait_irq(1);
    meas(16'h3C, 16'h2E, 16'h0, 16'h0);
    // zero duty on ch1 keeps its pin inactive
    wr(`TPW_OFF_CCR1, 32'h0);
    wait_irq(2);
    meas(16'h14, 16'h0, 16'h0, 16'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
